// [rtl/txn_decoder_regs.svh]
`ifndef TXN_DECODER_REGS_SVH
`define TXN_DECODER_REGS_SVH

// register byte offsets on the apb side
`define OFS_CTRL        8'h00
`define OFS_BLOCK_PTR   8'h04
`define OFS_WIN_BASE    8'h08
`define OFS_STATUS      8'h0c
`define OFS_DEST_NODE   8'h10
`define OFS_DEST_SVC    8'h14
`define OFS_FUNC        8'h18
`define OFS_RESULT_PTR  8'h1c
`define OFS_KINDS       8'h20

// control and status bit positions
`define CTRL_START      0
`define CTRL_HOST_ORIG  1
`define STAT_BUSY       0
`define STAT_DONE       1
`define STAT_INVALID    2
`define STAT_ALIGN_ERR  3
`define STAT_INLINE     4
`define STAT_PARAM_REQ  5

// gateway_txn_block layout, in 32-bit word indexes
`define BLOCK_BYTES     32'd96
`define BLOCK_WORDS     5'd24
`define ALIGN_MASK      32'h0000000f
`define W_DEST_NODE     0
`define W_DEST_SVC      1
`define W_FUNC          2
`define W_DESC_BASE     3
`define W_RESULT_PTR    19
`define W_PARAMS        20

// field codes
`define MAJOR_APP       8'h02
`define REGISTRY_SVC    32'h00000001
`define INLINE_MAX      32'd16
`define TYPE_NO_DATA    8'h0b
`define TYPE_DIRECT     8'h0c
`define TYPE_GATHER     8'h0d

`endif

// [rtl/txn_decoder_pkg.sv]
package txn_decoder_pkg;

  typedef enum logic [1:0] {KIND_NONE, KIND_DIRECT, KIND_LIST, KIND_BAD} data_kind_e;

  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_FETCH, ST_CHECK, ST_PREQ, ST_DISP} txn_state_e;

  typedef struct packed {
    data_kind_e  kind;
    logic [7:0]  list_entry_count;
    logic [31:0] addr;
    logic [31:0] offset;
    logic [31:0] length;
  } desc_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] len;
  } dma_req_s;

  typedef struct packed {
    logic [31:0]  dest_node;
    logic [31:0]  dest_service;
    logic [15:0]  minor_func;
    logic         to_registry;
    logic [31:0]  result_addr;
    logic         params_inline;
    logic [127:0] params;
    desc_s [3:0]  desc;
  } dispatch_s;

endpackage

// [rtl/transaction_descriptor_decoder.sv]
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "txn_decoder_regs.svh"
// What this block does
// - block is 96 bytes, 16-byte aligned; fetched whole in one dma read.
// - adapter memory references are window offsets; bus address adds window base.
// - word at byte 0 is the 32-bit destination node.
// - word at byte 4 is the 32-bit destination service.
// - service value one always routes to the registry service.
// - byte 8 top byte must be zero, major code must be 02h.
// - low two bytes of the word at byte 8 are the minor function code.
// - parameters up to 16 bytes sit inline at bytes 80-95; descriptor ignored.
// - longer parameters need exactly one extra dma fetch after the block.
// - descriptor at bytes 28-43 covers master-to-slave data.
// - descriptor at bytes 44-59 covers slave-to-master data.
// - descriptor at bytes 60-75 locates the status area.
// - word at byte 76 points at the result word, translated by origin.
// - type 0bh no data, 0ch direct, 0dh gather list, others reserved.
// - list entry count used only for gather list type.
// - descriptor address is bus address or window offset by origin.
// - direct descriptor offset is added to find the first data byte; a list keeps its base.
// - descriptor length is an upper bound in bytes on the transfer.
// - each list entry is an address word then a length word.
module transaction_descriptor_decoder
  import txn_decoder_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             dma_req_valid,
  input  wire logic        dma_req_ready,
  output dma_req_s         dma_req,
  input  wire logic        dma_rsp_valid,
  input  wire logic [31:0] dma_rsp_data,
  output logic             disp_valid,
  input  wire logic        disp_ready,
  output dispatch_s        disp
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  txn_state_e  state_ff;
  txn_state_e  nxt_state;
  logic [31:0] blk_ff [24];
  logic [4:0]  cnt_ff;
  logic [4:0]  nxt_cnt;
  logic        host_orig_ff;
  logic [31:0] block_ptr_ff;
  logic [31:0] win_base_ff;
  logic        done_ff;
  logic        invalid_ff;
  logic        align_err_ff;
  logic        param_req_ff;
  logic        nxt_done;
  logic        nxt_invalid;
  logic        nxt_align_err;
  logic        nxt_param_req;
  dma_req_s    dma_req_ff;
  dma_req_s    nxt_dma_req;
  dispatch_s   disp_ff;
  dispatch_s   nxt_disp;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire         wr_acc    = psel & penable & pwrite;
  wire         rd_setup  = psel & ~penable & ~pwrite;
  wire         hit_ctrl  = (paddr == `OFS_CTRL);
  wire         hit_ptr   = (paddr == `OFS_BLOCK_PTR);
  wire         hit_win   = (paddr == `OFS_WIN_BASE);
  wire         hit_stat  = (paddr == `OFS_STATUS);
  wire         hit_node  = (paddr == `OFS_DEST_NODE);
  wire         hit_svc   = (paddr == `OFS_DEST_SVC);
  wire         hit_func  = (paddr == `OFS_FUNC);
  wire         hit_res   = (paddr == `OFS_RESULT_PTR);
  wire         hit_kinds = (paddr == `OFS_KINDS);
  wire         addr_hit  = hit_ctrl | hit_ptr | hit_win | hit_stat | hit_node | hit_svc
                         | hit_func | hit_res | hit_kinds;
  wire         busy      = (state_ff != ST_IDLE);
  // start while busy is dropped: the local copy must not be overwritten mid-decode
  wire         start     = wr_acc & hit_ctrl & pwdata[`CTRL_START] & ~busy;
  wire         cfg_wr    = wr_acc & ~busy;
  wire         misalign  = (block_ptr_ff & `ALIGN_MASK) != 32'h0;
  // origin bit written with start must steer the very first fetch
  wire [31:0]  fetch_addr = pwdata[`CTRL_HOST_ORIG] ? block_ptr_ff : win_base_ff + block_ptr_ff;

  wire [31:0]  status_word = {26'h0, param_req_ff, disp_ff.params_inline, align_err_ff,
                              invalid_ff, done_ff, busy};
  wire [31:0]  kinds_word  = {24'h0, disp_ff.desc[3].kind, disp_ff.desc[2].kind,
                              disp_ff.desc[1].kind, disp_ff.desc[0].kind};

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  assign nxt_prdata = ~rd_setup ? prdata_ff
                    : hit_ctrl  ? {30'h0, host_orig_ff, 1'b0}
                    : hit_ptr   ? block_ptr_ff
                    : hit_win   ? win_base_ff
                    : hit_stat  ? status_word
                    : hit_node  ? disp_ff.dest_node
                    : hit_svc   ? disp_ff.dest_service
                    : hit_func  ? {16'h0, disp_ff.minor_func}
                    : hit_res   ? disp_ff.result_addr
                    : hit_kinds ? kinds_word
                    : 32'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // field decode of the stored block

  function automatic logic [31:0] xlate(input logic [31:0] a);
    // adapter-originated references are window offsets
    xlate = host_orig_ff ? a : win_base_ff + a;
  endfunction

  wire [31:0]  func_w       = blk_ff[`W_FUNC];
  wire [7:0]   major_code   = func_w[23:16];
  wire         func_bad     = (func_w[31:24] != 8'h0) | (major_code != `MAJOR_APP);
  wire [31:0]  param_len    = blk_ff[`W_DESC_BASE + 3];
  wire         param_inline = (param_len <= `INLINE_MAX);
  desc_s       desc_dec [4];
  logic [3:0]  desc_bad;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_desc
      // slot 0 parameters, 1 transmit, 2 receive, 3 status
      wire [31:0]  w_hdr  = blk_ff[`W_DESC_BASE + 4 * g];
      wire [31:0]  w_addr = blk_ff[`W_DESC_BASE + 4 * g + 1];
      wire [31:0]  w_ofs  = blk_ff[`W_DESC_BASE + 4 * g + 2];
      wire [31:0]  w_len  = blk_ff[`W_DESC_BASE + 4 * g + 3];
      wire [7:0]   t      = w_hdr[31:24];
      wire data_kind_e kind = (t == `TYPE_NO_DATA) ? KIND_NONE
                            : (t == `TYPE_DIRECT)  ? KIND_DIRECT
                            : (t == `TYPE_GATHER)  ? KIND_LIST
                            : KIND_BAD;
      // direct data starts at address plus logical offset; a list keeps its base
      wire [31:0]  start_a = (kind == KIND_DIRECT) ? xlate(w_addr + w_ofs)
                                                   : xlate(w_addr);
      assign desc_dec[g] = '{kind:             kind,
                             list_entry_count: (kind == KIND_LIST) ? w_hdr[23:16] : 8'h0,
                             addr:             start_a,
                             offset:           w_ofs,
                             length:           w_len};
      assign desc_bad[g] = (kind == KIND_BAD);
    end
  endgenerate

  // inline parameter descriptor fields are ignored, type included
  wire         txn_bad   = func_bad | (|desc_bad[3:1])
                         | (~param_inline & desc_bad[0]);
  // list length in bytes: two words per entry
  wire [31:0]  list_bytes = {21'h0, desc_dec[0].list_entry_count, 3'b000};
  wire [31:0]  preq_len   = (desc_dec[0].kind == KIND_LIST) ? list_bytes : param_len;

  ////////////////////////////////////////////////////////////////////////////////
  // sequence control

  assign dma_req_valid = (state_ff == ST_REQ) | (state_ff == ST_PREQ);
  assign dma_req       = dma_req_ff;
  assign disp_valid    = (state_ff == ST_DISP);
  assign disp          = disp_ff;
  assign prdata        = prdata_ff;

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_dma_req   = dma_req_ff;
    nxt_disp      = disp_ff;
    nxt_done      = done_ff;
    nxt_invalid   = invalid_ff;
    nxt_align_err = align_err_ff;
    nxt_param_req = param_req_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (start)
        begin
          nxt_done      = 1'b0;
          nxt_invalid   = 1'b0;
          nxt_align_err = 1'b0;
          nxt_param_req = 1'b0;
          nxt_cnt       = 5'd0;
          if (misalign)
          begin
            // no fetch for a pointer that breaks the 16-byte alignment
            nxt_align_err = 1'b1;
            nxt_invalid   = 1'b1;
            nxt_done      = 1'b1;
          end
          else
          begin
            nxt_dma_req = '{addr: fetch_addr, len: `BLOCK_BYTES};
            nxt_state   = ST_REQ;
          end
        end
      end
      ST_REQ:
      begin
        if (dma_req_ready)
          nxt_state = ST_FETCH;
      end
      ST_FETCH:
      begin
        if (dma_rsp_valid)
        begin
          nxt_cnt = cnt_ff + 5'd1;
          if (cnt_ff == `BLOCK_WORDS - 5'd1)
            nxt_state = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        nxt_disp.dest_node     = blk_ff[`W_DEST_NODE];
        nxt_disp.dest_service  = blk_ff[`W_DEST_SVC];
        nxt_disp.minor_func    = func_w[15:0];
        nxt_disp.to_registry   = (blk_ff[`W_DEST_SVC] == `REGISTRY_SVC);
        nxt_disp.result_addr   = xlate(blk_ff[`W_RESULT_PTR]);
        nxt_disp.params_inline = param_inline;
        nxt_disp.params        = {blk_ff[`W_PARAMS + 3], blk_ff[`W_PARAMS + 2],
                                  blk_ff[`W_PARAMS + 1], blk_ff[`W_PARAMS]};
        nxt_disp.desc[0]       = desc_dec[0];
        nxt_disp.desc[1]       = desc_dec[1];
        nxt_disp.desc[2]       = desc_dec[2];
        nxt_disp.desc[3]       = desc_dec[3];
        if (txn_bad)
        begin
          nxt_invalid = 1'b1;
          nxt_done    = 1'b1;
          nxt_state   = ST_IDLE;
        end
        else if (!param_inline)
        begin
          nxt_dma_req   = '{addr: desc_dec[0].addr, len: preq_len};
          nxt_param_req = 1'b1;
          nxt_state     = ST_PREQ;
        end
        else
          nxt_state = ST_DISP;
      end
      ST_PREQ:
      begin
        if (dma_req_ready)
          nxt_state = ST_DISP;
      end
      ST_DISP:
      begin
        if (disp_ready)
        begin
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 5'd0;
      dma_req_ff   <= '0;
      disp_ff      <= '0;
      done_ff      <= 1'b0;
      invalid_ff   <= 1'b0;
      align_err_ff <= 1'b0;
      param_req_ff <= 1'b0;
      prdata_ff    <= 32'h0;
    end
    else
    begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      dma_req_ff   <= nxt_dma_req;
      disp_ff      <= nxt_disp;
      done_ff      <= nxt_done;
      invalid_ff   <= nxt_invalid;
      align_err_ff <= nxt_align_err;
      param_req_ff <= nxt_param_req;
      prdata_ff    <= nxt_prdata;
    end
  end

  // config is frozen while a block is in flight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_orig_ff <= 1'b0;
      block_ptr_ff <= 32'h0;
      win_base_ff  <= 32'h0;
    end
    else
    begin
      if (cfg_wr && hit_ctrl)
        host_orig_ff <= pwdata[`CTRL_HOST_ORIG];
      if (cfg_wr && hit_ptr)
        block_ptr_ff <= pwdata;
      if (cfg_wr && hit_win)
        win_base_ff <= pwdata;
    end
  end

  // local copy of the block; the host must not change it meanwhile anyway
  generate
    for (g = 0; g < 24; g++)
    begin : g_blk
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          blk_ff[g] <= 32'h0;
        else if (state_ff == ST_FETCH && dma_rsp_valid && cnt_ff == 5'(g))
          blk_ff[g] <= dma_rsp_data;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  align_reject_a : assert property (
    (state_ff == ST_IDLE && start && misalign) |=> (state_ff == ST_IDLE) && align_err_ff
      && invalid_ff && !dma_req_valid)
    else $error("misaligned block pointer was not rejected");

  fetch_size_a : assert property (
    (state_ff == ST_REQ) |-> dma_req_valid && dma_req.len == 32'd96
      && (dma_req.addr[3:0] == 4'h0 || !host_orig_ff))
    else $error("block fetch length or alignment wrong");

  fetch_words_a : assert property (
    (state_ff == ST_FETCH && dma_rsp_valid && cnt_ff == 5'd23) |=> (state_ff == ST_CHECK))
    else $error("block fetch did not end after 24 words");

  node_svc_a : assert property (
    (state_ff == ST_CHECK) |=> disp.dest_node == $past(blk_ff[0])
      && disp.dest_service == $past(blk_ff[1]))
    else $error("destination fields not taken from bytes 0 and 4");

  service_word_a : assert property (
    disp_valid |-> disp.dest_service == blk_ff[1])
    else $error("dispatched service differs from block word");

  registry_route_a : assert property (
    disp_valid |-> disp.to_registry == (disp.dest_service == 32'h00000001))
    else $error("registry routing flag wrong");

  major_check_a : assert property (
    (state_ff == ST_CHECK && blk_ff[2][23:16] != 8'h02) |=> invalid_ff && !disp_valid
      && !dma_req_valid)
    else $error("bad major code not flagged invalid");

  minor_code_a : assert property (
    disp_valid |-> disp.minor_func == blk_ff[2][15:0])
    else $error("minor code not from low half of byte 8 word");

  inline_param_a : assert property (
    (state_ff == ST_CHECK && blk_ff[6] <= 32'd16 && !func_bad && desc_bad[3:1] == 3'b000)
      |=> disp_valid && disp.params_inline && disp.params[31:0] == blk_ff[20])
    else $error("inline parameters not dispatched directly");

  param_fetch_a : assert property (
    (state_ff == ST_CHECK && !txn_bad && blk_ff[6] > 32'd16) |=> dma_req_valid
      && state_ff == ST_PREQ && !disp_valid ##[1:1000] disp_valid)
    else $error("long parameters did not cause one extra fetch");

  kind_decode_a : assert property (
    (state_ff == ST_CHECK && blk_ff[7][31:24] == 8'h0c) |=> disp.desc[1].kind == KIND_DIRECT)
    else $error("direct type code not decoded");

  list_count_a : assert property (
    (state_ff == ST_CHECK) |=> (disp.desc[2].kind != KIND_LIST)
      -> disp.desc[2].list_entry_count == 8'h0)
    else $error("list count leaked for non-list descriptor");

  origin_xlate_a : assert property (
    (state_ff == ST_CHECK && !host_orig_ff) |=> disp.result_addr
      == win_base_ff + $past(blk_ff[19]))
    else $error("window offset not translated");

  bad_type_a : assert property (
    (state_ff == ST_CHECK && desc_bad[3:1] != 3'b000) ##1 1'b1 [*1] |-> !disp_valid
      && invalid_ff && done_ff)
    else $error("reserved descriptor type not flagged");

endmodule // transaction_descriptor_decoder

// [tb/host_mem_model.sv]
`timescale 1ns/1ps
module host_mem_model
  import txn_decoder_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        dma_req_valid,
  input  dma_req_s         dma_req,
  output logic             dma_req_ready,
  output logic             dma_rsp_valid,
  output logic      [31:0] dma_rsp_data
);
  // host memory, 1 KiB, word indexed; tb writes it between transactions
  logic [31:0] mem [0:255];
  logic [4:0]  left_ff;
  logic [7:0]  idx_ff;
  logic [1:0]  gap_ff;
  int          n_req;
  logic [31:0] last_addr;
  logic [31:0] last_len;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_req_ready <= 1'b0;
      dma_rsp_valid <= 1'b0;
      dma_rsp_data  <= 32'h0;
      left_ff       <= 5'h0;
      idx_ff        <= 8'h0;
      gap_ff        <= 2'h0;
      n_req         <= 0;
    end
    else
    begin
      dma_req_ready <= 1'b0;
      dma_rsp_valid <= 1'b0;
      gap_ff        <= gap_ff + 2'h1;
      if (dma_req_valid && !dma_req_ready && left_ff == 5'h0 && (!slow || gap_ff == 2'h3))
        dma_req_ready <= 1'b1;
      if (dma_req_valid && dma_req_ready)
      begin
        n_req     <= n_req + 1;
        last_addr <= dma_req.addr;
        last_len  <= dma_req.len;
        // only the block fetch is answered with data: one burst of 24 words
        if (dma_req.len == 32'd96)
        begin
          left_ff <= 5'd24;
          idx_ff  <= dma_req.addr[9:2];
        end
      end
      else if (left_ff != 5'h0 && (!slow || gap_ff[0]))
      begin
        dma_rsp_valid <= 1'b1;
        dma_rsp_data  <= mem[idx_ff];
        idx_ff        <= idx_ff + 8'h1;
        left_ff       <= left_ff - 5'h1;
      end
      else
        dma_rsp_data <= ~dma_rsp_data; // no stale data between words
    end
  end
endmodule // host_mem_model

// [tb/tb.sv]
`timescale 1ns/1ps
`include "txn_decoder_regs.svh"
module tb;
  import txn_decoder_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, st, q;
  logic        dma_req_valid, dma_req_ready, dma_rsp_valid, disp_valid, disp_ready, slow, e;
  logic [31:0] dma_rsp_data;
  dma_req_s    dma_req;
  dispatch_s   disp, got;
  int          n_fail, compares;

  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  transaction_descriptor_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_req_valid(dma_req_valid),
    .dma_req_ready(dma_req_ready), .dma_req(dma_req), .dma_rsp_valid(dma_rsp_valid),
    .dma_rsp_data(dma_rsp_data), .disp_valid(disp_valid), .disp_ready(disp_ready),
    .disp(disp));
  host_mem_model host (.pclk(pclk), .presetn(presetn), .slow(slow),
    .dma_req_valid(dma_req_valid), .dma_req(dma_req), .dma_req_ready(dma_req_ready),
    .dma_rsp_valid(dma_rsp_valid), .dma_rsp_data(dma_rsp_data));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [95:0] g, input logic [95:0] x);
    compares++;
    if (g !== x)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // idle edge first, so psel is never assigned twice in one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic hdr(input int b, input logic [31:0] svc, w2, res);
    host.mem[b] = 32'hcafe0011;
    host.mem[b+1] = svc;
    host.mem[b+2] = w2;
    host.mem[b+19] = res;
    for (int i = 20; i < 24; i++) host.mem[b+i] = 32'h11111111 * i;
  endtask

  task automatic dsc(input int b, s, input logic [7:0] tp, cnt, input logic [31:0] ad, of, ln);
    host.mem[b+3+4*s] = {tp, cnt, 16'h0};
    host.mem[b+4+4*s] = ad;
    host.mem[b+5+4*s] = of;
    host.mem[b+6+4*s] = ln;
  endtask

  // start a transaction, take the dispatch if one comes, then read status
  task automatic run(input logic [31:0] ptr, ctl);
    apb(1'b1, `OFS_BLOCK_PTR, ptr);
    apb(1'b1, `OFS_CTRL, ctl | 32'h1);
    for (int i = 0; i < 300 && disp_valid !== 1'b1; i++) @(posedge pclk);
    got = '0;
    if (disp_valid === 1'b1)
    begin
      got = disp;
      disp_ready <= 1'b1;
      @(posedge pclk);
      disp_ready <= 1'b0;
    end
    apb(1'b0, `OFS_STATUS, 32'h0);
    st = q;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(q, 32'h0);
    apb(1'b1, 8'h40, 32'h5);
    check(e, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    check({e, q}, {1'b1, 32'h0});
  endtask

  task automatic s_direct();
    hdr(16, `REGISTRY_SVC, 32'h00021234, 32'h500);
    dsc(16, 0, 8'h0e, 8'h0, 32'h0, 32'h0, 32'h8);
    dsc(16, 1, `TYPE_DIRECT, 8'h7, 32'h100, 32'h8, 32'h20);
    dsc(16, 2, `TYPE_NO_DATA, 8'h0, 32'h0, 32'h0, 32'h0);
    dsc(16, 3, `TYPE_GATHER, 8'h3, 32'h200, 32'h0, 32'h18);
    run(32'h40, 32'h2);
    check(host.n_req, 1);
    check({host.last_addr, host.last_len}, {32'h40, 32'd96});
    check(got.dest_node, 32'hcafe0011);
    check(got.dest_service, 32'h1);
    check(got.to_registry, 1'b1);
    check(got.minor_func, 16'h1234);
    check(got.result_addr, 32'h500);
    check(got.params_inline, 1'b1);
    check({got.desc[1].kind, got.desc[1].addr, got.desc[1].length},
          {KIND_DIRECT, 32'h108, 32'h20});
    check(got.desc[2].kind, KIND_NONE);
    check({got.desc[3].kind, got.desc[3].list_entry_count, got.desc[3].addr},
          {KIND_LIST, 8'h3, 32'h200});
    check(st[`STAT_INVALID:`STAT_DONE], 2'b01);
    apb(1'b0, `OFS_KINDS, 32'h0);
    check(q[7:2], 6'b100001);
    apb(1'b0, `OFS_FUNC, 32'h0);
    check(q[15:0], 16'h1234);
  endtask

  task automatic s_window();
    slow <= 1'b1;
    hdr(32, 32'h5, 32'h0002beef, 32'h20);
    dsc(32, 0, `TYPE_DIRECT, 8'h0, 32'h300, 32'h0, 32'h20);
    dsc(32, 1, `TYPE_DIRECT, 8'h0, 32'h100, 32'h4, 32'h10);
    dsc(32, 2, `TYPE_NO_DATA, 8'h0, 32'h0, 32'h0, 32'h0);
    dsc(32, 3, `TYPE_NO_DATA, 8'h0, 32'h0, 32'h0, 32'h0);
    apb(1'b1, `OFS_WIN_BASE, 32'h10000000);
    run(32'h80, 32'h0);
    check(host.n_req, 3);
    check({host.last_addr, host.last_len}, {32'h10000300, 32'h20});
    check({got.to_registry, got.params_inline}, 2'b00);
    check(got.result_addr, 32'h10000020);
    check(got.desc[1].addr, 32'h10000104);
    apb(1'b0, `OFS_RESULT_PTR, 32'h0);
    check(q, 32'h10000020);
    dsc(32, 0, `TYPE_GATHER, 8'h3, 32'h300, 32'h0, 32'h20);
    run(32'h80, 32'h0);
    check(host.n_req, 5);
    check({host.last_addr, host.last_len}, {32'h10000300, 32'd24});
    slow <= 1'b0;
  endtask

  task automatic s_invalid();
    logic [31:0] w2 [3] = '{32'h00030001, 32'h01020001, 32'h00020001};
    for (int k = 0; k < 3; k++)
    begin
      hdr(48, 32'h6, w2[k], 32'h0);
      for (int j = 0; j < 4; j++)
        dsc(48, j, (k == 2 && j == 1) ? 8'h0e : `TYPE_NO_DATA, 8'h0, 32'h0, 32'h0, 32'h0);
      run(32'hc0, 32'h2);
      check(host.n_req, 6 + k);
      check({got.dest_node, st[`STAT_INVALID:`STAT_DONE]}, {32'h0, 2'b11});
    end
    run(32'hc8, 32'h2);
    check(host.n_req, 8);
    check(st[`STAT_ALIGN_ERR:`STAT_DONE], 3'b111);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end

  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h0; pwdata = 32'h0;
    disp_ready = 0; slow = 0; n_fail = 0; compares = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_direct();
    s_window();
    s_invalid();
    wrap_up();
  end
endmodule // tb
